// ==== core/spu_pkg.sv ====
package spu_pkg;
  // system clock and the gear clock derived from it
  localparam int CLOCK_KHZ = 200000;
  localparam int GEAR_DIV_W = 5;
  localparam logic [GEAR_DIV_W-1:0] GEAR_LAST = 5'h13; // 200 MHz / 20 = 10 MHz gear

  typedef logic [21:0] spu_count_type;
  typedef logic [7:0]  spu_byte_type;

  // entry bytes and operation codes
  localparam spu_byte_type SYNC_FIRST    = 8'h86;
  localparam spu_byte_type SYNC_SECOND   = 8'h79;
  localparam spu_byte_type OP_WRITE      = 8'h30;
  localparam spu_byte_type OP_READ       = 8'h40;
  localparam spu_byte_type OP_RAM_LOAD   = 8'h60;
  localparam spu_byte_type OP_FLASH_SUM  = 8'h90;
  localparam spu_byte_type OP_PRODUCT_ID = 8'hC0;
  localparam spu_byte_type OP_STATUS     = 8'hC3;
  localparam spu_byte_type OP_EMU_SETUP  = 8'hD0;
  localparam spu_byte_type OP_ERASE      = 8'hF0;
  localparam spu_byte_type OP_SECURE     = 8'hFA;

  // reply values
  localparam spu_byte_type REPLY_OK   = 8'h5A;
  localparam spu_byte_type REPLY_FAIL = 8'hA5;
  localparam spu_byte_type ERASED     = 8'hFF;
  localparam spu_byte_type READ_FILL  = 8'h00;

  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;

  // device response delays, gear-clock cycles
  localparam int FIRST_SYNC_ECHO_DELAY      = 660;
  localparam int SECOND_SYNC_ECHO_DELAY     = 540;
  localparam int COMMAND_ECHO_DELAY         = 300;
  localparam int FLASH_SUM_TIME             = 1493340;
  localparam int RAM_SUM_TIME               = 160;
  localparam int WRITE_REPLY_DELAY          = 200;
  localparam int READ_REPLY_DELAY           = 430;
  localparam int EMULATION_SETUP_ECHO_DELAY = 420;
  localparam int SECURITY_ENABLE_TIME       = 1080;

  // host minimum waits
  localparam int POWER_ON_HOLD_LOW_TIME_MS  = 10;
  localparam int RELEASE_TO_RECEIVE_TIME_MS = 20;
  localparam int FIRST_SYNC_TURNAROUND      = 140;
  localparam int SECOND_SYNC_TURNAROUND     = 90;
  localparam int COMMAND_TURNAROUND         = 270;
  localparam int NEXT_COMMAND_GAP           = 1100;

  function automatic logic spu_needs_arg(input spu_byte_type op);
    spu_needs_arg = (op == OP_WRITE) || (op == OP_READ) || (op == OP_RAM_LOAD)
                 || (op == OP_EMU_SETUP) || (op == OP_ERASE);
  endfunction : spu_needs_arg

  // bytes that follow the command echo
  function automatic spu_byte_type spu_reply_count(input spu_byte_type op,
                                                   input spu_byte_type arg);
    if (op == OP_READ)
      spu_reply_count = arg;
    else if (spu_needs_arg(op) || (op == OP_FLASH_SUM) || (op == OP_PRODUCT_ID)
             || (op == OP_STATUS) || (op == OP_SECURE))
      spu_reply_count = 8'h01;
    else
      spu_reply_count = 8'h00;
  endfunction : spu_reply_count
endpackage : spu_pkg

// ==== core/spu_link_if.sv ====
`timescale 1ns/1ps
interface spu_link_if;
  logic       prog_mode;
  logic       reset_n;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] h2d_data;
  logic       d2h_valid;
  logic       d2h_ready;
  logic [7:0] d2h_data;

  modport dev (
    input  prog_mode, reset_n, h2d_valid, h2d_data, d2h_ready,
    output h2d_ready, d2h_valid, d2h_data
  );
  modport host (
    output prog_mode, reset_n, h2d_valid, h2d_data, d2h_ready,
    input  h2d_ready, d2h_valid, d2h_data
  );
endinterface : spu_link_if

// ==== core/spu_fifo.sv ====
`timescale 1ns/1ps
module spu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)(
  // system
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire              empty = (wr_ptr == rd_ptr);
  wire              push  = i_in_valid && !full;
  wire              pop   = i_out_ready && !empty;

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = store[rd_ptr[AW-1:0]];

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (push)
      store[wr_ptr[AW-1:0]] <= i_in_data;
  end
endmodule : spu_fifo

// ==== core/spu_device_end.sv ====
`timescale 1ns/1ps
module spu_device_end
  import spu_pkg::*;
#(
  parameter spu_count_type FIRST_SYNC_TICKS  = spu_count_type'(FIRST_SYNC_ECHO_DELAY),
  parameter spu_count_type SECOND_SYNC_TICKS = spu_count_type'(SECOND_SYNC_ECHO_DELAY),
  parameter spu_count_type CMD_ECHO_TICKS    = spu_count_type'(COMMAND_ECHO_DELAY),
  parameter spu_count_type FLASH_SUM_TICKS   = spu_count_type'(FLASH_SUM_TIME),
  parameter spu_count_type RAM_SUM_TICKS     = spu_count_type'(RAM_SUM_TIME),
  parameter spu_count_type WRITE_TICKS       = spu_count_type'(WRITE_REPLY_DELAY),
  parameter spu_count_type READ_TICKS        = spu_count_type'(READ_REPLY_DELAY),
  parameter spu_count_type EMU_TICKS         = spu_count_type'(EMULATION_SETUP_ECHO_DELAY),
  parameter spu_count_type SECURE_TICKS      = spu_count_type'(SECURITY_ENABLE_TIME),
  parameter spu_byte_type  PRODUCT_ID        = 8'h3C, // arbitrary value
  parameter spu_byte_type  ERASE_PASSWORD    = 8'hA6
)(
  // system
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // link to the programming host
  spu_link_if.dev   link,
  // user side
  output logic       o_secured,
  output logic [7:0] o_emu_setup,
  output logic       o_busy
);
  typedef enum {ST_SYNC1, ST_SYNC2, ST_CMD, ST_EXEC, ST_ARG,
                ST_DELAY, ST_PUSH, ST_READ} spu_dev_state_type;

  spu_dev_state_type       state;
  spu_dev_state_type       dst;
  spu_dev_state_type       ret;
  logic [GEAR_DIV_W-1:0]   gear_div;
  logic                    gear_tick;
  spu_count_type           cnt;
  spu_byte_type            op;
  spu_byte_type            pend;
  spu_byte_type            rd_left;
  logic [MEM_AW-1:0]       rd_idx;
  logic [MEM_AW-1:0]       wr_ptr;
  spu_byte_type            flash_sum;
  spu_byte_type            mem [MEM_DEPTH];
  logic                    fifo_ready;

  wire active    = link.prog_mode && link.reset_n;
  wire rx_open   = active && ((state == ST_SYNC1) || (state == ST_SYNC2)
                   || (state == ST_CMD) || (state == ST_ARG));
  wire rx_fire   = link.h2d_valid && rx_open;
  wire spu_byte_type rx_byte = link.h2d_data;
  wire arg_fire  = rx_fire && (state == ST_ARG);
  wire mem_we    = arg_fire && (op == OP_WRITE);
  wire erase_ok  = arg_fire && (op == OP_ERASE) && (rx_byte == ERASE_PASSWORD);
  wire spu_byte_type read_byte = o_secured ? READ_FILL : mem[rd_idx];
  wire reading   = (state == ST_READ) && (rd_left != 8'h00);
  wire push      = (state == ST_PUSH) || reading;
  wire spu_byte_type push_data = reading ? read_byte : pend;
  wire push_fire = push && fifo_ready;
  wire spu_byte_type overwrite = (mem[wr_ptr] == ERASED) ? REPLY_OK : REPLY_FAIL;

  assign link.h2d_ready = rx_open;

  // replies queue here so the host may stall the return path
  spu_fifo #(
    .WIDTH (8),
    .DEPTH (4)
  ) u_reply_fifo (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (push),
    .i_in_data   (push_data),
    .o_in_ready  (fifo_ready),
    .o_out_valid (link.d2h_valid),
    .o_out_data  (link.d2h_data),
    .i_out_ready (link.d2h_ready)
  );

  // gear clock enable
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      gear_div  <= '0;
      gear_tick <= 1'b0;
    end
    else
    begin
      gear_tick <= (gear_div == GEAR_LAST);
      gear_div  <= (gear_div == GEAR_LAST) ? '0 : gear_div + 1'b1;
    end
  end

  // image store, running flash checksum
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < MEM_DEPTH; i++)
        mem[i] <= ERASED;
      wr_ptr    <= '0;
      flash_sum <= '0;
    end
    else if (erase_ok)
    begin
      for (int i = 0; i < MEM_DEPTH; i++)
        mem[i] <= ERASED;
      wr_ptr    <= '0;
      flash_sum <= '0;
    end
    else if (mem_we)
    begin
      mem[wr_ptr] <= rx_byte;
      wr_ptr      <= wr_ptr + 1'b1;
      flash_sum   <= flash_sum + rx_byte;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_busy <= 1'b0;
    else
      o_busy <= !rx_open;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state       <= ST_SYNC1;
      dst         <= ST_PUSH;
      ret         <= ST_SYNC1;
      cnt         <= '0;
      op          <= '0;
      pend        <= '0;
      rd_left     <= '0;
      rd_idx      <= '0;
      o_secured   <= 1'b0;
      o_emu_setup <= '0;
    end
    else if (!active)
      state <= ST_SYNC1;
    else
    begin
      unique case (state)
        ST_SYNC1:
          if (rx_fire && (rx_byte == SYNC_FIRST))
          begin
            pend  <= rx_byte;
            cnt   <= FIRST_SYNC_TICKS;
            dst   <= ST_PUSH;
            ret   <= ST_SYNC2;
            state <= ST_DELAY;
          end
        ST_SYNC2:
          if (rx_fire && (rx_byte == SYNC_SECOND))
          begin
            pend  <= rx_byte;
            cnt   <= SECOND_SYNC_TICKS;
            dst   <= ST_PUSH;
            ret   <= ST_CMD;
            state <= ST_DELAY;
          end
        ST_CMD:
          if (rx_fire)
          begin
            op    <= rx_byte;
            pend  <= rx_byte;
            cnt   <= CMD_ECHO_TICKS;
            dst   <= ST_PUSH;
            ret   <= ST_EXEC;
            state <= ST_DELAY;
          end
        ST_EXEC:
        begin
          dst <= ST_PUSH;
          ret <= ST_CMD;
          if (spu_needs_arg(op))
            state <= ST_ARG;
          else if (op == OP_FLASH_SUM)
          begin
            pend  <= flash_sum;
            cnt   <= FLASH_SUM_TICKS;
            state <= ST_DELAY;
          end
          else if (op == OP_PRODUCT_ID)
          begin
            pend  <= PRODUCT_ID;
            state <= ST_PUSH;
          end
          else if (op == OP_STATUS)
          begin
            pend  <= o_secured ? REPLY_FAIL : REPLY_OK;
            state <= ST_PUSH;
          end
          else if (op == OP_SECURE)
          begin
            o_secured <= 1'b1;
            pend      <= REPLY_OK;
            cnt       <= SECURE_TICKS;
            state     <= ST_DELAY;
          end
          else
            state <= ST_CMD;
        end
        ST_ARG:
          if (rx_fire)
          begin
            state <= ST_DELAY;
            if (op == OP_WRITE)
            begin
              pend <= overwrite;
              cnt  <= WRITE_TICKS;
            end
            else if (op == OP_READ)
            begin
              rd_left <= rx_byte;
              rd_idx  <= '0;
              cnt     <= READ_TICKS;
              dst     <= ST_READ;
            end
            else if (op == OP_RAM_LOAD)
            begin
              pend <= rx_byte;
              cnt  <= RAM_SUM_TICKS;
            end
            else if (op == OP_EMU_SETUP)
            begin
              o_emu_setup <= rx_byte;
              pend        <= rx_byte;
              cnt         <= EMU_TICKS;
            end
            else
            begin
              pend  <= erase_ok ? REPLY_OK : REPLY_FAIL;
              state <= ST_PUSH;
              if (erase_ok)
                o_secured <= 1'b0;
            end
          end
        ST_DELAY:
          if (gear_tick)
          begin
            if (cnt <= spu_count_type'(1))
              state <= dst;
            else
              cnt <= cnt - 1'b1;
          end
        ST_PUSH:
          if (push_fire)
            state <= ret;
        ST_READ:
          if (!reading)
            state <= ST_CMD;
          else if (push_fire)
          begin
            rd_left <= rd_left - 1'b1;
            rd_idx  <= rd_idx + 1'b1;
          end
      endcase
    end
  end
endmodule : spu_device_end

// ==== core/spu_host_end.sv ====
`timescale 1ns/1ps
module spu_host_end
  import spu_pkg::*;
#(
  parameter spu_count_type HOLD_CYCLES    = spu_count_type'(POWER_ON_HOLD_LOW_TIME_MS * CLOCK_KHZ),
  parameter spu_count_type SETTLE_CYCLES  = spu_count_type'(RELEASE_TO_RECEIVE_TIME_MS * CLOCK_KHZ),
  parameter spu_count_type TURN1_TICKS    = spu_count_type'(FIRST_SYNC_TURNAROUND),
  parameter spu_count_type TURN2_TICKS    = spu_count_type'(SECOND_SYNC_TURNAROUND),
  parameter spu_count_type TURN3_TICKS    = spu_count_type'(COMMAND_TURNAROUND),
  parameter spu_count_type GAP_TICKS      = spu_count_type'(NEXT_COMMAND_GAP)
)(
  // system
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  // link to the device
  spu_link_if.host        link,
  // command port
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_op,
  input  wire logic [7:0] i_cmd_arg,
  output logic            o_cmd_ready,
  output logic            o_link_up,
  // reply port
  output logic            o_rsp_valid,
  output logic [7:0]      o_rsp_data,
  input  wire logic       i_rsp_ready
);
  typedef enum {H_HOLD, H_SETTLE, H_TX, H_ECHO, H_TURN, H_IDLE,
                H_TXARG, H_COLLECT, H_GAP} spu_host_state_type;
  typedef enum {PH_SYNC1, PH_SYNC2, PH_OP} spu_phase_type;

  spu_host_state_type    state;
  spu_phase_type         phase;
  logic [GEAR_DIV_W-1:0] gear_div;
  logic                  gear_tick;
  spu_count_type         tmr;
  spu_byte_type          op;
  spu_byte_type          arg;
  spu_byte_type          expect_left;
  logic                  tx_valid;
  spu_byte_type          tx_data;
  logic                  mode_q;
  logic                  reset_n_q;

  wire rx_fire  = link.d2h_valid && !o_rsp_valid;
  wire tx_fire  = tx_valid && link.h2d_ready;
  wire tmr_last = (tmr <= spu_count_type'(1));
  wire spu_byte_type want = spu_reply_count(op, arg);
  wire spu_count_type turn_ticks = (phase == PH_SYNC1) ? TURN1_TICKS :
                                   (phase == PH_SYNC2) ? TURN2_TICKS : TURN3_TICKS;

  assign link.prog_mode = mode_q;
  assign link.reset_n   = reset_n_q;
  assign link.h2d_valid = tx_valid;
  assign link.h2d_data  = tx_data;
  // replies that come early wait in the device queue until the host collects them
  assign link.d2h_ready = !o_rsp_valid && ((state == H_ECHO) || (state == H_COLLECT));

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      gear_div  <= '0;
      gear_tick <= 1'b0;
    end
    else
    begin
      gear_tick <= (gear_div == GEAR_LAST);
      gear_div  <= (gear_div == GEAR_LAST) ? '0 : gear_div + 1'b1;
    end
  end

  // replies of a command go to the user, who may stall the link
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= '0;
    end
    else if (rx_fire && (state == H_COLLECT))
    begin
      o_rsp_valid <= 1'b1;
      o_rsp_data  <= link.d2h_data;
    end
    else if (i_rsp_ready)
      o_rsp_valid <= 1'b0;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state       <= H_HOLD;
      phase       <= PH_SYNC1;
      tmr         <= HOLD_CYCLES;
      op          <= '0;
      arg         <= '0;
      expect_left <= '0;
      tx_valid    <= 1'b0;
      tx_data     <= '0;
      mode_q      <= 1'b0;
      reset_n_q   <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_link_up   <= 1'b0;
    end
    else
    begin
      unique case (state)
        H_HOLD:
          if (tmr_last)
          begin
            mode_q    <= 1'b1;
            reset_n_q <= 1'b1;
            tmr       <= SETTLE_CYCLES;
            state     <= H_SETTLE;
          end
          else
            tmr <= tmr - 1'b1;
        H_SETTLE:
          if (tmr_last)
          begin
            tx_valid <= 1'b1;
            tx_data  <= SYNC_FIRST;
            phase    <= PH_SYNC1;
            state    <= H_TX;
          end
          else
            tmr <= tmr - 1'b1;
        H_TX:
          if (tx_fire)
          begin
            tx_valid <= 1'b0;
            state    <= H_ECHO;
          end
        H_ECHO:
          if (rx_fire)
          begin
            tmr   <= turn_ticks;
            state <= H_TURN;
          end
        H_TURN:
          if (gear_tick && tmr_last)
          begin
            unique case (phase)
              PH_SYNC1:
              begin
                tx_valid <= 1'b1;
                tx_data  <= SYNC_SECOND;
                phase    <= PH_SYNC2;
                state    <= H_TX;
              end
              PH_SYNC2:
              begin
                o_link_up   <= 1'b1;
                o_cmd_ready <= 1'b1;
                state       <= H_IDLE;
              end
              PH_OP:
                if (spu_needs_arg(op))
                begin
                  tx_valid <= 1'b1;
                  tx_data  <= arg;
                  state    <= H_TXARG;
                end
                else
                begin
                  expect_left <= want;
                  tmr         <= GAP_TICKS;
                  state       <= (want == 8'h00) ? H_GAP : H_COLLECT;
                end
            endcase
          end
          else if (gear_tick)
            tmr <= tmr - 1'b1;
        H_IDLE:
          if (i_cmd_valid)
          begin
            op          <= i_cmd_op;
            arg         <= i_cmd_arg;
            tx_valid    <= 1'b1;
            tx_data     <= i_cmd_op;
            phase       <= PH_OP;
            o_cmd_ready <= 1'b0;
            state       <= H_TX;
          end
        H_TXARG:
          if (tx_fire)
          begin
            tx_valid    <= 1'b0;
            expect_left <= want;
            tmr         <= GAP_TICKS;
            state       <= (want == 8'h00) ? H_GAP : H_COLLECT;
          end
        H_COLLECT:
          if (rx_fire)
          begin
            expect_left <= expect_left - 1'b1;
            if (expect_left == 8'h01)
              state <= H_GAP;
          end
        H_GAP:
          if (gear_tick && tmr_last)
          begin
            o_cmd_ready <= 1'b1;
            state       <= H_IDLE;
          end
          else if (gear_tick)
            tmr <= tmr - 1'b1;
      endcase
    end
  end
endmodule : spu_host_end

// ==== verif/spu_link_asserts.sv ====
`timescale 1ns/1ps
module spu_link_asserts
  import spu_pkg::*;
#(
  parameter spu_count_type T1 = 6, T2 = 5, TC = 4, TF = 8, TM = 3, TW = 3, TR = 4,
  parameter spu_count_type TE = 4, TS = 5, HOLD = 40, SETTLE = 40, U1 = 2, U2 = 3,
  parameter spu_count_type U3 = 4, GAP = 6
)(
  // system
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  // link
  input  wire logic       prog_mode,
  input  wire logic       reset_n,
  input  wire logic       h2d_valid,
  input  wire logic       h2d_ready,
  input  wire logic [7:0] h2d_data,
  input  wire logic       d2h_valid,
  input  wire logic       d2h_ready,
  input  wire logic [7:0] d2h_data
);
  localparam int G = int'(GEAR_LAST) + 1;
  logic [1:0] ph, lastph;
  logic [7:0] op_q;
  logic       pending, stage2, cmd_seen, valid_q;
  int         since, since_echo, low_cnt, up_cnt;
  wire logic take = h2d_valid && h2d_ready;
  wire logic pop = d2h_valid && d2h_ready;
  wire logic rise = d2h_valid && !valid_q;
  wire logic arg_op = h2d_data inside {OP_WRITE, OP_READ, OP_RAM_LOAD, OP_EMU_SETUP, OP_ERASE};
  wire logic [1:0] next_ph = ph == 2'h0 ? 2'h1 : ph == 2'h1 ? 2'h2 : (ph == 2'h2 && arg_op) ? 2'h3 : 2'h2;
  wire logic two_stage = lastph == 2'h2 && !stage2 && op_q inside {OP_FLASH_SUM, OP_SECURE};
  wire integer exp_t = stage2 ? (op_q == OP_FLASH_SUM ? TF : TS) : lastph == 2'h0 ? T1
                 : lastph == 2'h1 ? T2 : lastph == 2'h2 ? TC : op_q == OP_WRITE ? TW
                 : op_q == OP_READ ? TR : op_q == OP_RAM_LOAD ? TM : op_q == OP_EMU_SETUP ? TE : 0;
  wire integer lo = exp_t == 0 ? 0 : (exp_t - 1) * G;
  wire integer hi = exp_t * G + 30;
  wire integer turn_min = ph == 2'h1 ? (U1 - 1) * G : ph == 2'h3 ? (U3 - 1) * G : (U2 - 1) * G;

  always_ff @(posedge i_clock or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      {ph, lastph, op_q, pending, stage2, cmd_seen, valid_q} <= '0;
      {since, since_echo, low_cnt, up_cnt} <= '0;
    end
    else
    begin
      valid_q <= d2h_valid;
      since <= since + 1;
      since_echo <= pop ? 0 : since_echo + 1;
      low_cnt <= reset_n ? low_cnt : low_cnt + 1;
      up_cnt <= reset_n ? up_cnt + 1 : 0;
      if (!reset_n)
      begin
        ph <= 2'h0;
        pending <= 1'b0;
        cmd_seen <= 1'b0;
      end
      else if (take)
      begin
        lastph <= ph;
        ph <= next_ph;
        since <= 0;
        pending <= 1'b1;
        stage2 <= 1'b0;
        if (ph == 2'h2)
        begin
          op_q <= h2d_data;
          cmd_seen <= 1'b1;
        end
      end
      else if (rise && pending)
      begin
        stage2 <= two_stage;
        pending <= two_stage;
        since <= 0;
      end
    end

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  hold_low_a: assert property ($rose(reset_n) || $rose(prog_mode) |-> low_cnt >= HOLD - 1)
    else $error("mode or reset pin released early");
  settle_a: assert property (take && ph == 2'h0 |-> up_cnt >= SETTLE - 1)
    else $error("first byte sent too soon");
  turn_wait_a: assert property (take && (ph != 2'h2 || !cmd_seen) && ph != 2'h0 |-> since_echo >= turn_min)
    else $error("byte sent too soon after echo");
  cmd_gap_a: assert property (take && ph == 2'h2 && cmd_seen |-> since_echo >= (GAP - 1) * G)
    else $error("command sent too soon");
  reply_early_a: assert property (rise && pending |-> since >= lo)
    else $error("reply came too early");
  reply_late_a: assert property (pending |-> since <= hi)
    else $error("reply came too late");
  sync_value_a: assert property (rise && pending && !lastph[1] |-> d2h_data == (lastph[0] ? SYNC_SECOND : SYNC_FIRST))
    else $error("wrong entry echo");
  echo_value_a: assert property (rise && pending && lastph == 2'h2 && !stage2 |-> d2h_data == op_q)
    else $error("wrong command echo");
  offer_hold_a: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("offered byte dropped");
  fifo_hold_a: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("reply byte dropped");
  cover property (rise && two_stage);
  cover property (take && ph == 2'h3);
  cover property (d2h_valid && !d2h_ready);
endmodule : spu_link_asserts

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import spu_pkg::*;
;
  localparam spu_count_type T1 = 22'h6, T2 = 22'h5, TC = 22'h4, TF = 22'h8, TM = 22'h3, TW = 22'h3;
  localparam spu_count_type TR = 22'h4, TE = 22'h4, TS = 22'h5, HOLD = 22'h28, SETTLE = 22'h28;
  localparam spu_count_type U1 = 22'h2, U2 = 22'h3, U3 = 22'h4, GAP = 22'h6;
  localparam spu_byte_type  PID = 8'h3C; // arbitrary value
  localparam spu_byte_type  PW = 8'hA6;
  logic         i_clock, i_sys_rst, cmd_valid, rsp_ready, cmd_ready, link_up, rsp_valid;
  logic         secured, busy, sec_m;
  logic [7:0]   cmd_op, cmd_arg, rsp_data, emu_setup;
  logic [15:0]  rnd;
  int           fails, num_checks, cycles, wptr;
  spu_byte_type img [16];
  spu_byte_type sum_m;
  spu_byte_type q [$];

  spu_link_if link();
  spu_device_end #(.FIRST_SYNC_TICKS(T1), .SECOND_SYNC_TICKS(T2), .CMD_ECHO_TICKS(TC),
    .FLASH_SUM_TICKS(TF), .RAM_SUM_TICKS(TM), .WRITE_TICKS(TW), .READ_TICKS(TR), .EMU_TICKS(TE),
    .SECURE_TICKS(TS), .PRODUCT_ID(PID), .ERASE_PASSWORD(PW)) spu_device_end_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(link), .o_secured(secured),
    .o_emu_setup(emu_setup), .o_busy(busy));
  spu_host_end #(.HOLD_CYCLES(HOLD), .SETTLE_CYCLES(SETTLE), .TURN1_TICKS(U1), .TURN2_TICKS(U2),
    .TURN3_TICKS(U3), .GAP_TICKS(GAP)) spu_host_end_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(link), .i_cmd_valid(cmd_valid),
    .i_cmd_op(cmd_op), .i_cmd_arg(cmd_arg), .o_cmd_ready(cmd_ready), .o_link_up(link_up),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .i_rsp_ready(rsp_ready));
  spu_link_asserts #(.T1(T1), .T2(T2), .TC(TC), .TF(TF), .TM(TM), .TW(TW), .TR(TR), .TE(TE),
    .TS(TS), .HOLD(HOLD), .SETTLE(SETTLE), .U1(U1), .U2(U2), .U3(U3), .GAP(GAP))
    spu_link_asserts_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .prog_mode(link.prog_mode), .reset_n(link.reset_n), .h2d_valid(link.h2d_valid),
    .h2d_ready(link.h2d_ready), .h2d_data(link.h2d_data), .d2h_valid(link.d2h_valid),
    .d2h_ready(link.d2h_ready), .d2h_data(link.d2h_data));

  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // expected reply bytes and flash image bookkeeping
  function automatic void model(input spu_byte_type op, input spu_byte_type arg);
    case (op)
      OP_WRITE:
      begin
        q.push_back(img[wptr] == ERASED ? REPLY_OK : REPLY_FAIL);
        img[wptr] = arg;
        wptr = (wptr + 1) % 16;
        sum_m += arg;
      end
      OP_READ: for (int i = 0; i < int'(arg); i++) q.push_back(sec_m ? READ_FILL : img[i % 16]);
      OP_RAM_LOAD, OP_EMU_SETUP: q.push_back(arg);
      OP_ERASE:
      begin
        q.push_back(arg == PW ? REPLY_OK : REPLY_FAIL);
        if (arg == PW)
        begin
          foreach (img[i]) img[i] = ERASED;
          {wptr, sec_m, sum_m} = '0;
        end
      end
      OP_FLASH_SUM: q.push_back(sum_m);
      OP_PRODUCT_ID: q.push_back(PID);
      OP_STATUS: q.push_back(sec_m ? REPLY_FAIL : REPLY_OK);
      OP_SECURE:
      begin
        q.push_back(REPLY_OK);
        sec_m = 1'b1;
      end
      default: ;
    endcase
  endfunction : model

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic run_cmd(input spu_byte_type op, input spu_byte_type arg, input int stall);
    model(op, arg);
    @(posedge i_clock);
    #1 cmd_valid = 1'b1;
    cmd_op = op;
    cmd_arg = arg;
    do @(negedge i_clock); while (cmd_ready !== 1'b1);
    @(posedge i_clock);
    #1 cmd_valid = 1'b0;
    while (q.size() > 0)
    begin
      @(negedge i_clock);
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
        check(rsp_data, q.pop_front());
      @(posedge i_clock);
      rnd = lfsr_next(rnd);
      #1 rsp_ready = stall > 0 ? 1'b0 : rnd[0] | rnd[1];
      stall--;
    end
    @(posedge i_clock);
    #1 rsp_ready = 1'b1;
    $display("command %h done", op);
  endtask : run_cmd

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  initial
  begin
    {i_sys_rst, cmd_valid, cmd_op, cmd_arg, rsp_ready} = {1'b1, 1'b0, 16'h0000, 1'b1};
    {fails, num_checks, cycles, wptr, sec_m, sum_m} = '0;
    rnd = 16'h5FE6;
    repeat (20) @(posedge i_clock);
    #1 i_sys_rst = 1'b0;
    while (link_up !== 1'b1) @(negedge i_clock);
    run_cmd(OP_ERASE, 8'h5B, 0);
    run_cmd(OP_ERASE, PW, 0);
    run_cmd(OP_STATUS, 8'h00, 0);
    run_cmd(OP_PRODUCT_ID, 8'h00, 0);
    repeat (5)
    begin
      rnd = lfsr_next(rnd);
      run_cmd(OP_WRITE, rnd[7:0], 0);
    end
    run_cmd(OP_FLASH_SUM, 8'h00, 0);
    run_cmd(OP_READ, 8'h06, 300);
    run_cmd(OP_RAM_LOAD, rnd[15:8], 0);
    run_cmd(OP_EMU_SETUP, rnd[11:4], 0);
    check(emu_setup, cmd_arg);
    run_cmd(8'h11, 8'h00, 0);
    check({7'h00, busy}, 8'h00);
    run_cmd(OP_SECURE, 8'h00, 0);
    check({7'h00, secured}, 8'h01);
    run_cmd(OP_STATUS, 8'h00, 0);
    run_cmd(OP_READ, 8'h03, 0);
    run_cmd(OP_ERASE, PW, 0);
    check({7'h00, secured}, 8'h00);
    tally_and_finish();
  end
endmodule : testbench
